// ---- src/sram_wmask_pkg.sv ----
// Constants, field layout and types shared by the byte-mask write port.
// Assumes a single 25 MHz system clock; the link is sampled, not clocked.
package sram_wmask_pkg;

    // Geometry
    localparam int LANE_W      = 9;
    localparam int LANES       = 4;
    localparam int DATA_W      = LANE_W * LANES;
    localparam int ADDR_W      = 19;
    localparam int SYNC_STAGES = 3;
    localparam int FIFO_DEPTH  = 32;

    // Register port
    localparam int          REG_AW      = 5;
    localparam logic [4:0]  OFF_CTRL    = 5'h00;
    localparam logic [4:0]  OFF_STATUS  = 5'h04;
    localparam logic [4:0]  OFF_COUNT   = 5'h08;
    localparam logic [4:0]  OFF_RDADDR  = 5'h0c;
    localparam logic [4:0]  OFF_RDDATA  = 5'h10;

    // Control fields
    localparam int CTRL_ORG_LSB  = 0;
    localparam int CTRL_HOLD_BIT = 2;

    // Status fields
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_DROP_BIT  = 8;
    localparam int STAT_PEND_BIT  = 9;

    // Reset values
    localparam logic [1:0]  ORG_RST   = 2'h2;
    localparam logic        HOLD_RST  = 1'b0;
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;

    // Bus organisation
    typedef enum logic [1:0] {ORG_X9, ORG_X18, ORG_X36} org_t;

    // Array drain sequencer
    typedef enum logic {DR_IDLE, DR_BEAT1} drain_t;

endpackage

// ---- src/wmask_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; full and empty are exact.
`timescale 1ns/100ps
`default_nettype none
module wmask_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int LVL_W = $clog2(DEPTH) + 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    // Fill level
    output logic [LVL_W-1:0]      level_o
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr_q;
    logic [PW:0]      rd_ptr_q;
    wire              push;
    wire              pop;
    wire              full;
    wire              empty;

    assign full        = (wr_ptr_q[PW] != rd_ptr_q[PW])
                       && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
    assign empty       = (wr_ptr_q == rd_ptr_q);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_ptr_q[PW-1:0]];
    assign push        = in_valid_i && !full;
    assign pop         = out_ready_i && !empty;
    assign level_o     = LVL_W'(wr_ptr_q - rd_ptr_q);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_q[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ---- src/sram_byte_write_mask_decode.sv ----
// Write port of a burst-of-two double-rate SRAM with per-byte write masks.
// Assumes the link clock pair is far slower than sys_clk_i (at least 8 to 1)
// and that the controller keeps data and masks steady around each edge.
//
// Overview of operation
// - Enables accompany every beat; sampled both clock edges.
// - x18: two enables select bytes per beat.
// - x36: four enables gate four bytes independently.
// - x9: one enable gates bits zero to eight.
// - Enables only matter inside an initiated write.
// - Enable n maps to data bits 9n..9n+8.
// - Write-select low at K; beats on K, then K#.
// - Address captured on following complement clock edge.
`timescale 1ns/100ps
`default_nettype none
module sram_byte_write_mask_decode
    import sram_wmask_pkg::*;
#(
    parameter int AW    = sram_wmask_pkg::ADDR_W,
    parameter int DEPTH = sram_wmask_pkg::FIFO_DEPTH
) (
    // System
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_i,
    // Link clock pair and write port pins
    input  wire logic                       k_i,
    input  wire logic                       k_n_i,
    input  wire logic                       write_sel_n_i,
    input  wire logic [AW-1:0]              addr_i,
    input  wire logic [sram_wmask_pkg::DATA_W-1:0] data_i,
    input  wire logic                       lane0_write_en_n,
    input  wire logic                       lane1_write_en_n,
    input  wire logic                       lane2_write_en_n,
    input  wire logic                       lane3_write_en_n,
    input  wire logic                       single_lane_write_en_n,
    // Back-pressure towards the controller
    output logic                            wr_ready_o,
    // Register port
    input  wire logic [sram_wmask_pkg::REG_AW-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic [31:0]                     reg_rdata_o
);

    import sram_wmask_pkg::*;

    localparam int PIN_W   = 3 + AW + DATA_W + LANES + 1;
    localparam int ENTRY_W = AW + 2 * (DATA_W + LANES);
    localparam int LVL_W   = $clog2(DEPTH) + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [PIN_W-1:0] sync_q [SYNC_STAGES];
    wire  [PIN_W-1:0] pins;
    wire  [PIN_W-1:0] pins_s2;
    wire  [PIN_W-1:0] pins_s3;
    logic             k_lvl_q;
    logic             kn_lvl_q;
    wire              k_stable;
    wire              kn_stable;
    wire              k_rise;
    wire              kn_rise;
    wire              wsel_n_s;
    wire  [AW-1:0]    addr_s;
    wire  [DATA_W-1:0] data_s;
    wire  [LANES-1:0] lane_n_s;
    wire              single_n_s;

    assign pins = {k_i, k_n_i, write_sel_n_i, addr_i, data_i,
                   lane3_write_en_n, lane2_write_en_n, lane1_write_en_n,
                   lane0_write_en_n, single_lane_write_en_n};

    always_ff @(posedge sys_clk_i)
    begin
        sync_q[0] <= pins;
        sync_q[1] <= sync_q[0];
        sync_q[2] <= sync_q[1];
    end

    assign pins_s2 = sync_q[1];
    assign pins_s3 = sync_q[2];
    assign {wsel_n_s, addr_s, data_s, lane_n_s, single_n_s} = pins_s3[PIN_W-3:0];

    // A clock level only changes once the last two stages agree
    assign k_stable  = (pins_s2[PIN_W-1] == pins_s3[PIN_W-1]);
    assign kn_stable = (pins_s2[PIN_W-2] == pins_s3[PIN_W-2]);
    assign k_rise    = k_stable && pins_s3[PIN_W-1] && !k_lvl_q;
    assign kn_rise   = kn_stable && pins_s3[PIN_W-2] && !kn_lvl_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            k_lvl_q  <= 1'b0;
            kn_lvl_q <= 1'b0;
        end
        else
        begin
            if (k_stable)
            begin
                k_lvl_q <= pins_s3[PIN_W-1];
            end
            if (kn_stable)
            begin
                kn_lvl_q <= pins_s3[PIN_W-2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and status registers
    logic [1:0]       org_q;
    logic             hold_q;
    logic             drop_q;
    logic [31:0]      count_q;
    logic [AW-1:0]    rdaddr_q;
    logic [31:0]      reg_rdata_q;
    org_t             org;
    wire              org_x9;
    wire              org_x18;
    wire              org_x36;
    wire              wr_ctrl;
    wire              wr_status;
    wire              wr_rdaddr;
    wire  [LVL_W-1:0] fifo_level;
    wire  [DATA_W-1:0] rd_word;
    wire  [31:0]      status_word;
    wire  [31:0]      rd_mux;
    logic             pend_q;

    assign org     = org_t'(org_q);
    assign org_x9  = (org == ORG_X9);
    assign org_x18 = (org == ORG_X18);
    // Unused code 3 behaves as the widest bus
    assign org_x36 = !org_x9 && !org_x18;

    assign wr_ctrl   = reg_wr_i && (reg_addr_i == OFF_CTRL);
    assign wr_status = reg_wr_i && (reg_addr_i == OFF_STATUS);
    assign wr_rdaddr = reg_wr_i && (reg_addr_i == OFF_RDADDR);

    assign status_word = (32'(fifo_level) << STAT_LEVEL_LSB)
                       | (32'(drop_q) << STAT_DROP_BIT)
                       | (32'(pend_q) << STAT_PEND_BIT);

    // Array read-back is limited to the low 32 bits of the word
    assign rd_mux = (reg_addr_i == OFF_CTRL)   ? {29'h0, hold_q, org_q} :
                    (reg_addr_i == OFF_STATUS) ? status_word :
                    (reg_addr_i == OFF_COUNT)  ? count_q :
                    (reg_addr_i == OFF_RDADDR) ? 32'(rdaddr_q) :
                    (reg_addr_i == OFF_RDDATA) ? rd_word[31:0] : 32'h0;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_q <= 32'h0;
        end
        else
        begin
            reg_rdata_q <= reg_rd_i ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata_o = reg_rdata_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            org_q    <= ORG_RST;
            hold_q   <= HOLD_RST;
            rdaddr_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                org_q  <= reg_wdata_i[CTRL_ORG_LSB +: 2];
                hold_q <= reg_wdata_i[CTRL_HOLD_BIT];
            end
            if (wr_rdaddr)
            begin
                rdaddr_q <= reg_wdata_i[AW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane enable decode per organisation
    logic [LANES-1:0] lane_en;

    always_comb
    begin
        if (org_x9)
        begin
            lane_en = {3'h0, !single_n_s};
        end
        else if (org_x18)
        begin
            lane_en = {2'h0, ~lane_n_s[1:0]};
        end
        else
        begin
            lane_en = org_x36 ? ~lane_n_s : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Beat capture on both link edges
    logic [DATA_W-1:0] beat0_data_q;
    logic [LANES-1:0]  beat0_en_q;
    wire               push_valid;
    wire               push_ready;
    wire [ENTRY_W-1:0] push_entry;

    // Second beat, its enables and the address go in on the K# edge
    assign push_valid = kn_rise && pend_q;
    assign push_entry = {addr_s, lane_en, data_s, beat0_en_q, beat0_data_q};
    assign wr_ready_o = push_ready;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pend_q       <= 1'b0;
            beat0_data_q <= '0;
            beat0_en_q   <= '0;
        end
        else if (k_rise)
        begin
            pend_q       <= !wsel_n_s;
            beat0_data_q <= data_s;
            beat0_en_q   <= wsel_n_s ? '0 : lane_en;
        end
        else if (kn_rise)
        begin
            pend_q <= 1'b0;
        end
    end

    // A write with no room is dropped and flagged; set wins over clear
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            drop_q  <= 1'b0;
            count_q <= COUNT_RST;
        end
        else
        begin
            if (push_valid && !push_ready)
            begin
                drop_q <= 1'b1;
            end
            else if (wr_status && reg_wdata_i[STAT_DROP_BIT])
            begin
                drop_q <= 1'b0;
            end
            if (push_valid && push_ready)
            begin
                count_q <= count_q + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write buffer between the link and the array
    wire               pop_valid;
    wire               pop_ready;
    wire [ENTRY_W-1:0] pop_entry;

    wmask_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (DEPTH),
        .LVL_W (LVL_W)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_entry),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_entry),
        .level_o     (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Drain: beat 0 at the address, beat 1 at the next one
    drain_t            dr_q;
    logic [AW-1:0]     dr_addr_q;
    logic [DATA_W-1:0] dr_data_q;
    logic [LANES-1:0]  dr_en_q;
    wire               pop;
    wire  [AW-1:0]     mem_addr;
    wire  [DATA_W-1:0] mem_data;
    wire  [LANES-1:0]  mem_en;

    // Hold lets software stall the array so the buffer really fills
    assign pop_ready = (dr_q == DR_IDLE) && !hold_q;
    assign pop       = pop_valid && pop_ready;
    assign mem_addr  = pop ? pop_entry[ENTRY_W-1 -: AW] : dr_addr_q;
    assign mem_data  = pop ? pop_entry[DATA_W-1:0] : dr_data_q;
    assign mem_en    = pop ? pop_entry[DATA_W +: LANES]
                     : ((dr_q == DR_BEAT1) ? dr_en_q : '0);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            dr_q      <= DR_IDLE;
            dr_addr_q <= '0;
            dr_data_q <= '0;
            dr_en_q   <= '0;
        end
        else
        begin
            unique case (dr_q)
                DR_IDLE:
                begin
                    if (pop)
                    begin
                        dr_q      <= DR_BEAT1;
                        dr_addr_q <= AW'(pop_entry[ENTRY_W-1 -: AW] + 1'b1);
                        dr_data_q <= pop_entry[DATA_W + LANES +: DATA_W];
                        dr_en_q   <= pop_entry[2 * DATA_W + LANES +: LANES];
                    end
                end
                DR_BEAT1:
                begin
                    dr_q <= DR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array, one byte-wide bank per lane
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            logic [LANE_W-1:0] bank [2**AW];

            always_ff @(posedge sys_clk_i)
            begin
                if (mem_en[g])
                begin
                    bank[mem_addr] <= mem_data[g*LANE_W +: LANE_W];
                end
            end

            assign rd_word[g*LANE_W +: LANE_W] = bank[rdaddr_q];
        end
    endgenerate

endmodule
`default_nettype wire

// ---- tb/wmask_monitor.sv ----
// Checker for the byte-mask write port, bound to its top module.
// Assumes link pins change away from sys_clk_i edges.
`timescale 1ns/100ps
`default_nettype none
module wmask_monitor
    import sram_wmask_pkg::*;
#(
    parameter int DEPTH = 32
) (
    // System
    input wire logic                             sys_clk_i,
    input wire logic                             rst_i,
    // Link
    input wire logic                             k_i,
    input wire logic                             k_n_i,
    input wire logic                             write_sel_n_i,
    input wire logic                             wr_ready_o,
    // Register port
    input wire logic [sram_wmask_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [31:0]                      reg_wdata_i,
    input wire logic                             reg_wr_i,
    input wire logic                             reg_rd_i,
    input wire logic [31:0]                      reg_rdata_o
);
    logic [3:0]  qc_q;
    logic [31:0] acc_q;
    logic        k_q;
    logic        kn_q;
    logic        ws_q;
    logic        hold_q;
    logic        drop_q;
    // Pin edges seen raw; the design sees them later, so reads wait for quiet
    wire         kn_rise = k_n_i && !kn_q;
    wire         push    = kn_rise && ws_q;
    wire         clr     = reg_wr_i && reg_addr_i == OFF_STATUS && reg_wdata_i[STAT_DROP_BIT];
    //////////////////////////////////////////
    always_ff @(posedge sys_clk_i)
    begin
        k_q  <= k_i;
        kn_q <= k_n_i;
        if (rst_i)
        begin
            qc_q   <= 4'h0;
            acc_q  <= 32'h0;
            ws_q   <= 1'b0;
            hold_q <= 1'b0;
            drop_q <= 1'b0;
        end
        else
        begin
            qc_q   <= (k_i != k_q || k_n_i != kn_q) ? 4'h0 : qc_q + {3'h0, qc_q != 4'hf};
            ws_q   <= (k_i && !k_q) ? !write_sel_n_i : ws_q;
            acc_q  <= acc_q + {31'h0, push && wr_ready_o};
            drop_q <= (push && !wr_ready_o) || (drop_q && !clr);
            if (reg_wr_i && reg_addr_i == OFF_CTRL)
                hold_q <= reg_wdata_i[CTRL_HOLD_BIT];
        end
    end
    //////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_qrd(logic [4:0] off);
        qc_q == 4'hf && reg_rd_i && reg_addr_i == off;
    endsequence
    property p_rd_zero; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    property p_unmapped; reg_rd_i && reg_addr_i == 5'h14 |=> reg_rdata_o == 32'h0; endproperty
    property p_rst; $fell(rst_i) |-> reg_rdata_o == 32'h0 && wr_ready_o; endproperty
    property p_count; s_qrd(OFF_COUNT) |=> reg_rdata_o == acc_q; endproperty
    property p_pend; s_qrd(OFF_STATUS) |=> !reg_rdata_o[STAT_PEND_BIT]; endproperty
    property p_drop; s_qrd(OFF_STATUS) |=> reg_rdata_o[STAT_DROP_BIT] == drop_q; endproperty
    property p_ready; acc_q < DEPTH |-> wr_ready_o; endproperty
    property p_full_hold; !wr_ready_o && hold_q |=> !wr_ready_o; endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("read data not zero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_rst: assert property (p_rst)
        else $error("bad reset outputs");
    a_count: assert property (p_count)
        else $error("write count wrong");
    a_pend: assert property (p_pend)
        else $error("write left pending");
    a_drop: assert property (p_drop)
        else $error("drop flag wrong");
    a_ready: assert property (p_ready)
        else $error("ready low with room");
    a_full_hold: assert property (p_full_hold)
        else $error("ready rose while held");
endmodule
bind sram_byte_write_mask_decode wmask_monitor #(.DEPTH(DEPTH)) u_mon (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .k_i(k_i), .k_n_i(k_n_i),
    .write_sel_n_i(write_sel_n_i), .wr_ready_o(wr_ready_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// ---- tb/ctrl_model.sv ----
// Memory controller model: link clock pair, select, address, beats, masks.
// Assumes a caller starts a burst only after the previous one returned.
`timescale 1ns/100ps
`default_nettype none
module ctrl_model #(
    parameter int AW = 6
) (
    // Link pins
    output logic          k_o,
    output logic          k_n_o,
    output logic          sel_n_o,
    output logic [AW-1:0] addr_o,
    output logic [35:0]   data_o,
    output logic [4:0]    en_n_o
);
    initial
    begin
        k_o     = 1'b0;
        k_n_o   = 1'b0;
        sel_n_o = 1'b1;
        addr_o  = '0;
        data_o  = 36'h0;
        en_n_o  = 5'h1f;
    end
    // Clocks stand still between bursts; released lines flip so stale data never match
    task automatic burst(input logic s, input logic [AW-1:0] a, input logic [35:0] d0,
                         input logic [35:0] d1, input logic [4:0] e0, input logic [4:0] e1);
        #5 sel_n_o = s;
        data_o  = d0;
        en_n_o  = e0;
        #40 k_o = 1'b1;
        #160 k_o = 1'b0;
        k_n_o   = 1'b1;
        data_o  = d1;
        en_n_o  = e1;
        addr_o  = a;
        sel_n_o = ~s;
        #150 data_o = ~d1;
        en_n_o  = ~e1;
        addr_o  = ~a;
        #10 k_n_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for the byte-mask write port: mask table, reset, buffer fill.
// Assumes the controller model in ctrl_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sram_wmask_pkg::*;
    localparam int AW = 6;
    logic          sys_clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic [4:0]    reg_addr_i = 5'h0;
    logic [31:0]   reg_wdata_i = 32'h0;
    logic          reg_wr_i = 1'b0;
    logic          reg_rd_i = 1'b0;
    logic [31:0]   reg_rdata_o;
    logic          wr_ready_o;
    logic          k;
    logic          kn;
    logic          sel_n;
    logic [AW-1:0] addr;
    logic [35:0]   data;
    logic [4:0]    en_n;
    logic [31:0]   v;
    int            miscompares = 0;
    int            checks = 0;
    // Org, select, address, masks of both beats, low words expected at a and a+1
    logic [82:0]   rows [9] = '{
        {2'h2, 1'b0, 6'h04, 5'h10, 5'h1f, 32'h0000_0000, 32'hffff_ffff},
        {2'h2, 1'b0, 6'h06, 5'h13, 5'h1e, 32'h0003_ffff, 32'hffff_fe00},
        {2'h2, 1'b0, 6'h08, 5'h1d, 5'h1b, 32'hfffc_01ff, 32'hf803_ffff},
        {2'h1, 1'b0, 6'h0a, 5'h10, 5'h17, 32'hfffc_0000, 32'hffff_ffff},
        {2'h1, 1'b0, 6'h0c, 5'h1e, 5'h1d, 32'hffff_fe00, 32'hfffc_01ff},
        {2'h0, 1'b0, 6'h0e, 5'h00, 5'h10, 32'hffff_fe00, 32'hffff_ffff},
        {2'h2, 1'b1, 6'h10, 5'h10, 5'h10, 32'hffff_ffff, 32'hffff_ffff},
        {2'h3, 1'b0, 6'h12, 5'h13, 5'h17, 32'h0003_ffff, 32'h07ff_ffff},
        {2'h2, 1'b0, 6'h3f, 5'h10, 5'h10, 32'h0000_0000, 32'h0000_0000}};
    ctrl_model #(.AW(AW)) m (.k_o(k), .k_n_o(kn), .sel_n_o(sel_n), .addr_o(addr),
        .data_o(data), .en_n_o(en_n));
    sram_byte_write_mask_decode #(.AW(AW), .DEPTH(FIFO_DEPTH)) uut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .k_i(k), .k_n_i(kn), .write_sel_n_i(sel_n),
        .addr_i(addr), .data_i(data), .lane0_write_en_n(en_n[0]), .lane1_write_en_n(en_n[1]),
        .lane2_write_en_n(en_n[2]), .lane3_write_en_n(en_n[3]),
        .single_lane_write_en_n(en_n[4]), .wr_ready_o(wr_ready_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o));
    always #20 sys_clk_i = ~sys_clk_i;
    //////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp32({31'h0, g}, {31'h0, e});
    endtask
    task automatic chk(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        cmp32(v, e);
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Poll until the buffer is drained; bounded so a stuck drain ends the run
    task automatic settle;
        for (int i = 0; i < 60; i++)
        begin
            rd(OFF_STATUS);
            if (v[5:0] === 6'h0 && v[9] === 1'b0)
                return;
        end
        miscompares++;
        finish_test;
    endtask
    //////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        foreach (rows[i])
        begin
            logic [AW-1:0] a;
            a = rows[i][79:74];
            wr(OFF_CTRL, {30'h0, ORG_RST});
            m.burst(1'b0, a, 36'hf_ffff_ffff, 36'hf_ffff_ffff, 5'h10, 5'h10);
            settle();
            wr(OFF_CTRL, {30'h0, rows[i][82:81]});
            m.burst(rows[i][80], a, 36'h0, 36'h0, rows[i][73:69], rows[i][68:64]);
            settle();
            wr(OFF_RDADDR, {26'h0, a});
            chk(OFF_RDDATA, rows[i][63:32]);
            wr(OFF_RDADDR, {26'h0, a + 6'h1});
            chk(OFF_RDDATA, rows[i][31:0]);
            $display("row %0d done", i);
        end
        chk(OFF_COUNT, 32'h0000_0011);
        // Second reset in mid-run, then reset values and unmapped access
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wr(5'h14, 32'hffff_ffff);
        chk(OFF_CTRL, {29'h0, HOLD_RST, ORG_RST});
        chk(OFF_COUNT, COUNT_RST);
        chk(OFF_STATUS, 32'h0);
        chk(5'h14, 32'h0);
        cmp1(wr_ready_o, 1'b1);
        $display("reset test done");
        // Drain held: one write past full must be dropped and flagged
        wr(OFF_CTRL, 32'h0000_0006);
        repeat (FIFO_DEPTH + 1) m.burst(1'b0, 6'h20, 36'h0, 36'h0, 5'h10, 5'h10);
        cmp1(wr_ready_o, 1'b0);
        chk(OFF_STATUS, 32'h0000_0120);
        wr(OFF_STATUS, 32'h0000_0100);
        wr(OFF_CTRL, {30'h0, ORG_RST});
        settle();
        chk(OFF_COUNT, 32'h0000_0020);
        chk(OFF_STATUS, 32'h0);
        cmp1(wr_ready_o, 1'b1);
        $display("fill test done");
        finish_test;
    end
endmodule
`default_nettype wire
